// File: src/i2cd_top.sv
/*
 * Two-wire data port with address extension, SMBus address match
 * and SCL low / bus-free timeouts, behind an AXI4-Lite slave.
 * Assumes open-drain SCL/SDA with pull-ups resolved outside, and
 * one 40 MHz clock with synchronous active-low reset.
 */
module i2cd_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Two-wire pins, enable low while pulling low
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oen,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oen
);
	i2cd_pkg::i2cd_st_t q_r, q_nxt;
	logic       aw_hs, w_hs, ar_hs, wr, we, rd_data, tick, tick_to;
	logic       scl_rise, scl_fall, start_c, stop_c, hit;
	logic       idle_b, host_ok, go_tx, go_rx, mst_on;
	logic [7:0] wd, ra;

	// ==========================================================
	// Handshakes; one write and one read in flight at most.
	assign awready = !q_r.aw_ok && !q_r.bvalid;
	assign wready  = !q_r.w_ok && !q_r.bvalid;
	assign arready = !q_r.rvalid;
	assign aw_hs   = awvalid && awready;
	assign w_hs    = wvalid && wready;
	assign ar_hs   = arvalid && arready;
	assign wr      = q_r.aw_ok && q_r.w_ok;
	assign we      = wr && q_r.w_s;
	assign wd      = q_r.w_d;
	assign ra      = araddr[7:0];
	assign rd_data = ar_hs && (ra == i2cd_pkg::OFF_DATA);

	// Outputs straight from the state record; scl_out and sda_out are tied low.
	assign bvalid  = q_r.bvalid;
	assign bresp   = q_r.bresp;
	assign rvalid  = q_r.rvalid;
	assign rresp   = q_r.rresp;
	assign rdata   = {24'h00_0000, q_r.rdata};
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oen = !q_r.scl_lo;
	assign sda_oen = !q_r.sda_lo;

	// ==========================================================
	// Line events, taken only once the last two stages agree.
	assign scl_rise = (q_r.scl_q[1] == q_r.scl_q[2]) && q_r.scl_q[2] && !q_r.scl_f;
	assign scl_fall = (q_r.scl_q[1] == q_r.scl_q[2]) && !q_r.scl_q[2] && q_r.scl_f;
	assign start_c  = q_r.scl_f && q_r.sda_f && (q_r.sda_q[1] == q_r.sda_q[2])
		&& !q_r.sda_q[2] && q_r.scl_q[2];
	assign stop_c   = q_r.scl_f && !q_r.sda_f && (q_r.sda_q[1] == q_r.sda_q[2])
		&& q_r.sda_q[2] && q_r.scl_q[2];

	// Half-period pacing and the timeout counter rate.
	assign tick    = (q_r.div == i2cd_pkg::HALF_M1);
	assign tick_to = q_r.smb[i2cd_pkg::SMB_TCK - 4] || (q_r.pre == i2cd_pkg::PRE_LAST); // [R14]
	assign mst_on  = (q_r.ms != i2cd_pkg::MS_IDLE);

	// Software may start a byte only between bytes.
	assign idle_b  = !q_r.act && !q_r.ack_w;
	assign host_ok = (q_r.ms == i2cd_pkg::MS_HOLD) || q_r.slv;
	assign go_tx   = we && (q_r.aw_a == i2cd_pkg::OFF_DATA) && q_r.tx && idle_b && host_ok; // [R1] [R4] [R5]
	assign go_rx   = rd_data && !q_r.tx && idle_b && host_ok; // [R2] [R4] [R5]

	// Calling address match on the received address byte.
	always_comb begin
		hit = 1'b0;
		if (!q_r.c2[i2cd_pkg::C2_ADDRESS_EXTENSION_BIT]) begin
			hit = (q_r.sh[7:1] == q_r.a1); // [R9]
		end else begin
			hit = (q_r.sh[7:3] == i2cd_pkg::TEN_HDR) && (q_r.sh[2:1] == q_r.c2[1:0]); // [R9] [R10]
		end
		if (q_r.c2[i2cd_pkg::C2_GENERAL_CALL_ENABLE] && (q_r.sh[7:1] == i2cd_pkg::GC_ADDR)) begin
			hit = 1'b1; // [R8]
		end
		if (q_r.smb[i2cd_pkg::SMB_ALRT - 4] && (q_r.sh[7:1] == i2cd_pkg::ALERT_ADDR)) begin
			hit = 1'b1; // [R12]
		end
		if (q_r.smb[i2cd_pkg::SMB_SIIC - 4] && (q_r.sh[7:1] == q_r.a2)) begin
			hit = 1'b1; // [R13] [R19] [R24]
		end
	end

	// ==========================================================
	// Next state: bus, software effects, then hardware sets so
	// that an event in the clearing cycle is kept.
	always_comb begin
		q_nxt = q_r;
		// Three-stage synchronisers.
		q_nxt.scl_q = {q_r.scl_q[1:0], scl_in};
		q_nxt.sda_q = {q_r.sda_q[1:0], sda_in};
		if (q_r.scl_q[1] == q_r.scl_q[2]) begin
			q_nxt.scl_f = q_r.scl_q[2];
		end
		if (q_r.sda_q[1] == q_r.sda_q[2]) begin
			q_nxt.sda_f = q_r.sda_q[2];
		end
		q_nxt.div = tick ? 8'h00 : q_r.div + 8'h01;
		q_nxt.pre = q_r.pre + 6'h01;

		// Bus slave: latch address and data, answer when both held.
		if (aw_hs) begin
			q_nxt.aw_ok = 1'b1;
			q_nxt.aw_a  = awaddr[7:0];
		end
		if (w_hs) begin
			q_nxt.w_ok = 1'b1;
			q_nxt.w_d  = wdata[7:0];
			q_nxt.w_s  = wstrb[0];
		end
		if (wr) begin
			q_nxt.aw_ok  = 1'b0;
			q_nxt.w_ok   = 1'b0;
			q_nxt.bvalid = 1'b1;
			q_nxt.bresp  = (q_r.aw_a > i2cd_pkg::OFF_A1 || q_r.aw_a[1:0] != 2'h0)
				? i2cd_pkg::RESP_SLV : i2cd_pkg::RESP_OKAY;
		end else if (q_r.bvalid && bready) begin
			q_nxt.bvalid = 1'b0;
		end
		if (ar_hs) begin
			q_nxt.rvalid = 1'b1;
			q_nxt.rresp  = i2cd_pkg::RESP_OKAY;
			case (ra)
				i2cd_pkg::OFF_DATA: q_nxt.rdata = q_r.rx_data; // [R6]
				i2cd_pkg::OFF_C2:   q_nxt.rdata = {q_r.c2[7:6], 3'h0, q_r.c2[2:0]};
				i2cd_pkg::OFF_SMB:  q_nxt.rdata = {q_r.smb, q_r.scl_low_timeout_flag, q_r.bus_free_high_timeout_flag, 2'h0};
				i2cd_pkg::OFF_A2:   q_nxt.rdata = {q_r.a2, 1'b0};
				i2cd_pkg::OFF_SLTH: q_nxt.rdata = q_r.slt[15:8];
				i2cd_pkg::OFF_SLTL: q_nxt.rdata = q_r.slt[7:0];
				i2cd_pkg::OFF_CTRL: q_nxt.rdata = {2'h0, q_r.master_select_bit, q_r.tx, q_r.acknowledge_control_bit, q_r.repeated_start_bit, 2'h0};
				i2cd_pkg::OFF_STAT: q_nxt.rdata = {q_r.transfer_complete_flag, q_r.addressed_as_slave_flag, q_r.busy, q_r.arbl,
					1'b0, q_r.srw, q_r.iif, q_r.rxak};
				i2cd_pkg::OFF_A1:   q_nxt.rdata = {q_r.a1, 1'b0};
				default: begin
					q_nxt.rdata = 8'h00;
					q_nxt.rresp = i2cd_pkg::RESP_SLV;
				end
			endcase
		end else if (q_r.rvalid && rready) begin
			q_nxt.rvalid = 1'b0;
		end

		// Register writes and their side effects.
		if (we) begin
			case (q_r.aw_a)
				i2cd_pkg::OFF_C2:   q_nxt.c2 = {wd[7:6], 3'h0, wd[2:0]}; // [R8] [R9] [R10]
				i2cd_pkg::OFF_SMB: begin
					q_nxt.smb = wd[7:4]; // [R11] [R12] [R13] [R14]
					if (wd[i2cd_pkg::SMB_SCL_LOW_TIMEOUT_FLAG]) begin
						q_nxt.scl_low_timeout_flag = 1'b0; // [R15]
					end
				end
				i2cd_pkg::OFF_A2:   q_nxt.a2 = wd[7:1]; // [R19]
				i2cd_pkg::OFF_SLTH: q_nxt.slt[15:8] = wd; // [R20]
				i2cd_pkg::OFF_SLTL: q_nxt.slt[7:0] = wd; // [R20]
				i2cd_pkg::OFF_A1:   q_nxt.a1 = wd[7:1];
				i2cd_pkg::OFF_CTRL: begin
					q_nxt.master_select_bit  = wd[i2cd_pkg::CT_MST];
					q_nxt.tx   = wd[i2cd_pkg::CT_TX];
					q_nxt.acknowledge_control_bit = wd[i2cd_pkg::CT_ACKNOWLEDGE_CONTROL_BIT];
					q_nxt.repeated_start_bit = wd[i2cd_pkg::CT_REPEATED_START_BIT];
					q_nxt.addressed_as_slave_flag = 1'b0;
					// A waiting fast acknowledge goes out now.
					if (q_r.ack_w) begin
						q_nxt.ack_w  = 1'b0;
						q_nxt.sda_lo = !wd[i2cd_pkg::CT_ACKNOWLEDGE_CONTROL_BIT]; // [R11]
						if (!mst_on) begin
							q_nxt.scl_lo = 1'b0;
						end
					end
				end
				i2cd_pkg::OFF_STAT: begin
					if (wd[i2cd_pkg::ST_ARBL]) begin
						q_nxt.arbl = 1'b0;
					end
					if (wd[i2cd_pkg::ST_IIF]) begin
						q_nxt.iif  = 1'b0;
						q_nxt.scl_low_timeout_flag = 1'b0; // [R15]
					end
				end
				default: q_nxt.repeated_start_bit = q_r.repeated_start_bit;
			endcase
		end

		// Software starts a byte; writes never reach rx_data.
		if (go_tx || go_rx) begin
			q_nxt.act    = 1'b1;
			q_nxt.cnt    = 4'h0;
			q_nxt.transfer_complete_flag    = 1'b0; // [R23]
			q_nxt.d_tx   = go_tx;
			q_nxt.ack_v  = q_r.acknowledge_control_bit; // [R11]
			q_nxt.addr_b = q_r.first; // [R7]
			q_nxt.first  = 1'b0;
			q_nxt.sh     = go_tx ? wd : 8'h00;
			q_nxt.sda_lo = go_tx && !wd[7]; // [R1]
			if (mst_on) begin
				q_nxt.ms = i2cd_pkg::MS_BYTE;
			end else begin
				q_nxt.scl_lo = 1'b0;
			end
		end

		// Bus start and stop seen by everybody.
		if (start_c) begin
			q_nxt.busy = 1'b1;
			if (!mst_on) begin
				q_nxt.act    = 1'b1;
				q_nxt.cnt    = 4'h0;
				q_nxt.d_tx   = 1'b0;
				q_nxt.addr_b = 1'b1;
				q_nxt.slv    = 1'b0;
			end
		end
		if (stop_c) begin
			q_nxt.busy = 1'b0;
			q_nxt.slv  = 1'b0;
			if (!mst_on) begin
				q_nxt.act    = 1'b0;
				q_nxt.sda_lo = 1'b0;
				q_nxt.scl_lo = 1'b0;
			end
		end

		// Bit engine: sample on SCL rise, drive on SCL fall.
		if (q_r.act && scl_rise) begin
			if (q_r.cnt[3]) begin
				q_nxt.rxak = q_r.sda_f;
			end else if (!q_r.d_tx) begin
				q_nxt.sh = {q_r.sh[6:0], q_r.sda_f};
			end else if (mst_on && !q_r.sda_lo && !q_r.sda_f) begin
				// Someone else holds SDA low: give the bus up.
				q_nxt.arbl   = 1'b1;
				q_nxt.iif    = 1'b1;
				q_nxt.master_select_bit    = 1'b0;
				q_nxt.ms     = i2cd_pkg::MS_IDLE;
				q_nxt.act    = 1'b0;
				q_nxt.scl_lo = 1'b0;
				q_nxt.sda_lo = 1'b0;
			end
		end
		if (q_r.act && scl_fall) begin
			if (q_r.cnt < 4'h7) begin
				q_nxt.cnt = q_r.cnt + 4'h1;
				if (q_r.d_tx) begin
					q_nxt.sh     = {q_r.sh[6:0], 1'b0};
					q_nxt.sda_lo = !q_r.sh[6]; // [R1]
				end
			end else if (q_r.cnt == 4'h7) begin
				q_nxt.cnt    = 4'h8;
				q_nxt.sda_lo = 1'b0;
				if (!q_r.d_tx && !mst_on && q_r.addr_b) begin
					if (hit) begin
						q_nxt.slv    = 1'b1; // [R24]
						q_nxt.addressed_as_slave_flag   = 1'b1; // [R24]
						q_nxt.srw    = q_r.sh[0];
						q_nxt.iif    = 1'b1;
						q_nxt.sda_lo = 1'b1;
						q_nxt.rx_data = q_r.sh;
					end else begin
						q_nxt.act = 1'b0;
					end
				end else if (!q_r.d_tx && q_r.smb[i2cd_pkg::SMB_FAST_ACKNOWLEDGE_ENABLE - 4] && !q_r.addr_b) begin
					// Hold SCL low until software chooses ACK or NACK.
					q_nxt.ack_w   = 1'b1; // [R11]
					q_nxt.iif     = 1'b1;
					q_nxt.rx_data = q_r.sh;
					q_nxt.scl_lo  = 1'b1;
				end else if (!q_r.d_tx) begin
					q_nxt.sda_lo = !q_r.ack_v; // [R11]
				end
			end else begin
				q_nxt.act    = 1'b0;
				q_nxt.sda_lo = 1'b0;
				q_nxt.transfer_complete_flag    = 1'b1;
				q_nxt.iif    = 1'b1;
				if (!q_r.d_tx) begin
					q_nxt.rx_data = q_r.sh; // [R6]
				end
				// A slave stretches SCL until software acts, unless the byte it sent was NACKed.
				if (!mst_on) begin
					q_nxt.scl_lo = 1'b1;
					if (q_r.d_tx && q_r.rxak) begin
						q_nxt.slv    = 1'b0;
						q_nxt.scl_lo = 1'b0;
					end
				end
			end
		end

		// Master sequencer, paced by the half-period tick.
		case (q_r.ms)
			i2cd_pkg::MS_IDLE: begin
				if (q_r.master_select_bit && !q_r.busy && tick) begin
					q_nxt.sda_lo = 1'b1;
					q_nxt.ms     = i2cd_pkg::MS_START;
				end
			end
			i2cd_pkg::MS_START: begin
				if (tick) begin
					q_nxt.scl_lo = 1'b1;
					q_nxt.first  = 1'b1; // [R7]
					q_nxt.repeated_start_bit   = 1'b0;
					q_nxt.ms     = i2cd_pkg::MS_HOLD;
				end
			end
			i2cd_pkg::MS_HOLD: begin
				if (!q_r.master_select_bit) begin
					q_nxt.sda_lo = 1'b1;
					q_nxt.ms     = i2cd_pkg::MS_STOP;
				end else if (q_r.repeated_start_bit) begin
					q_nxt.sda_lo = 1'b0;
					q_nxt.ms     = i2cd_pkg::MS_RSTRT;
				end
			end
			i2cd_pkg::MS_BYTE: begin
				if (!q_r.act) begin
					q_nxt.scl_lo = 1'b1;
					q_nxt.ms     = i2cd_pkg::MS_HOLD;
				end else if (tick && !q_r.ack_w) begin
					q_nxt.scl_lo = !q_r.scl_lo;
				end
			end
			i2cd_pkg::MS_STOP: begin
				if (tick && q_r.scl_lo) begin
					q_nxt.scl_lo = 1'b0;
				end else if (tick) begin
					q_nxt.sda_lo = 1'b0;
					q_nxt.ms     = i2cd_pkg::MS_IDLE;
				end
			end
			i2cd_pkg::MS_RSTRT: begin
				if (tick && q_r.scl_lo) begin
					q_nxt.scl_lo = 1'b0;
				end else if (tick) begin
					q_nxt.sda_lo = 1'b1;
					q_nxt.ms     = i2cd_pkg::MS_START;
				end
			end
			default: q_nxt.ms = i2cd_pkg::MS_IDLE;
		endcase

		// Low timeout: counts while SCL low, off when value is zero.
		if (q_r.slt == 16'h0000 || q_r.scl_f) begin
			q_nxt.lo_cnt = 16'h0000; // [R16] [R21]
		end else if (tick_to && q_r.lo_cnt != q_r.slt) begin
			q_nxt.lo_cnt = q_r.lo_cnt + 16'h0001; // [R21]
			if (q_r.lo_cnt + 16'h0001 == q_r.slt) begin
				q_nxt.scl_low_timeout_flag = 1'b1; // [R15]
				q_nxt.iif  = 1'b1; // [R22]
			end
		end
		// Bus-free detect: both lines high beyond value/512 ticks.
		if (!(q_r.scl_f && q_r.sda_f)) begin
			q_nxt.hi_cnt = 16'h0000;
		end else if (tick_to && q_r.hi_cnt != 16'hffff) begin
			q_nxt.hi_cnt = q_r.hi_cnt + 16'h0001;
		end
		q_nxt.bus_free_high_timeout_flag = q_r.scl_f && q_r.sda_f && (q_r.hi_cnt > {9'h000, q_r.slt[15:9]}); // [R17]
	end

	// ==========================================================
	// The only register stage; reset loads constants only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r       <= '0;
			q_r.scl_q <= 3'h7;
			q_r.sda_q <= 3'h7;
			q_r.scl_f <= 1'b1;
			q_r.sda_f <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tx_msb_first: assert property (go_tx |=> q_r.act && q_r.d_tx && q_r.sda_lo == !$past(wd[7])) // [R1]
		else $error("transmit byte did not start with its top bit");
	a_rx_on_read: assert property (go_rx |=> q_r.act && !q_r.d_tx && !q_r.transfer_complete_flag) // [R2]
		else $error("data read did not start a receive");
	a_dir_block: assert property (rd_data && q_r.tx && !q_r.act |=> !q_r.act) // [R5]
		else $error("read started a transfer in transmit direction");
	a_read_rxdata: assert property (rd_data |=> q_r.rdata == $past(q_r.rx_data)) // [R6]
		else $error("data read did not return last received byte");
	a_lo_disabled: assert property (q_r.slt == 16'h0000 |=> !$rose(q_r.scl_low_timeout_flag)) // [R16]
		else $error("low timeout flagged with zero value");
	a_lo_restart: assert property (q_r.scl_f |=> q_r.lo_cnt == 16'h0000) // [R21]
		else $error("low counter not restarted while SCL high");
	a_hi_clear: assert property (!(q_r.scl_f && q_r.sda_f) |=> !q_r.bus_free_high_timeout_flag) // [R17]
		else $error("high timeout flag stayed with a line low");
	a_slt_irq: assert property ($rose(q_r.scl_low_timeout_flag) |-> q_r.iif) // [R22]
		else $error("low timeout did not raise the pending flag");
	a_tcf_clear: assert property (go_tx || go_rx |=> !q_r.transfer_complete_flag ##1 q_r.act) // [R23]
		else $error("complete flag kept on a new transfer");
	a_r_hold: assert property (q_r.rvalid && !rready |=> q_r.rvalid && $stable(q_r.rdata))
		else $error("read answer changed before it was taken");

	c_low_timeout: cover property ($rose(q_r.scl_low_timeout_flag));
	c_slave_hit:   cover property ($rose(q_r.slv));
	c_byte_done:   cover property ($rose(q_r.transfer_complete_flag));
	c_fast_ack:    cover property ($rose(q_r.ack_w));
endmodule

// File: src/i2cd_pkg.sv
/*
 * Constants, types and state record for the two-wire data port,
 * address extension, SMBus and timeout block.
 * Assumes a 40 MHz bus clock and an AXI4-Lite master for software.
 */
// How it works
// R1 - Writing data in transmit sends byte MSB first
// R2 - Reading data in master receive fetches next byte
// R3 - Software switches direction before final data read
// R4 - Addressed slave gets same data port behaviour
// R5 - Transfer starts only if direction matches access
// R6 - Data read returns last received byte only
// R7 - First byte after start carries address plus direction
// R8 - General call enable bit seven allows general call
// R9 - Extension bit six picks 7 or 10 bit
// R10 - Bits 2:0 give upper 10-bit address bits
// R11 - Fast acknowledge lets software ack current byte
// R12 - Bit six enables alert response address match
// R13 - Bit five enables second address comparison
// R14 - Bit four picks bus clock or bus/64
// R15 - Low timeout flag sets, clears by software
// R16 - Zero low timeout value disables low detection
// R17 - High timeout flag marks bus free, self-clears
// R18 - Software ignores high flag at full rate
// R19 - Second address register bits 7:1 hold address
// R20 - Low timeout value is upper and lower byte
// R21 - Low counter runs while SCL low, restarts high
// R22 - Timeouts also raise the interrupt pending flag; here only the low timeout does
// R23 - Data access in matching direction clears complete
// R24 - Second address match sets addressed as slave
package i2cd_pkg;
	// ==========================================================
	// Timing
	localparam int         CLK_HZ   = 40_000_000;
	localparam int         SCL_HZ   = 100_000;
	localparam int         HALF_CYC = CLK_HZ / (2 * SCL_HZ);
	localparam logic [7:0] HALF_M1  = 8'(HALF_CYC - 1);
	localparam logic [5:0] PRE_LAST = 6'h3f;
	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_C2   = 8'h04;
	localparam logic [7:0] OFF_SMB  = 8'h08;
	localparam logic [7:0] OFF_A2   = 8'h0c;
	localparam logic [7:0] OFF_SLTH = 8'h10;
	localparam logic [7:0] OFF_SLTL = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	localparam logic [7:0] OFF_A1   = 8'h20;
	// ==========================================================
	// Field positions
	localparam int C2_GENERAL_CALL_ENABLE = 7;
	localparam int C2_ADDRESS_EXTENSION_BIT = 6;
	localparam int SMB_FAST_ACKNOWLEDGE_ENABLE = 7;
	localparam int SMB_ALRT = 6;
	localparam int SMB_SIIC = 5;
	localparam int SMB_TCK  = 4;
	localparam int SMB_SCL_LOW_TIMEOUT_FLAG = 3;
	localparam int SMB_BUS_FREE_HIGH_TIMEOUT_FLAG = 2;
	localparam int CT_MST   = 5;
	localparam int CT_TX    = 4;
	localparam int CT_ACKNOWLEDGE_CONTROL_BIT  = 3;
	localparam int CT_REPEATED_START_BIT  = 2;
	localparam int ST_TCF   = 7;
	localparam int ST_ADDRESSED_AS_SLAVE_FLAG  = 6;
	localparam int ST_BUSY  = 5;
	localparam int ST_ARBL  = 4;
	localparam int ST_SRW   = 2;
	localparam int ST_IIF   = 1;
	localparam int ST_RXAK  = 0;
	// ==========================================================
	// Fixed addresses and answers
	localparam logic [6:0] GC_ADDR    = 7'h00;
	localparam logic [6:0] ALERT_ADDR = 7'h0c;
	localparam logic [4:0] TEN_HDR    = 5'h1e;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;
	// ==========================================================
	// Master sequencer, Gray along idle-start-hold-byte
	typedef enum logic [2:0] {
		MS_IDLE  = 3'h0,
		MS_START = 3'h1,
		MS_HOLD  = 3'h3,
		MS_BYTE  = 3'h2,
		MS_STOP  = 3'h6,
		MS_RSTRT = 3'h7
	} i2cd_ms_t;
	// ==========================================================
	// Whole state of the block
	typedef struct packed {
		logic       aw_ok, w_ok, w_s, bvalid, rvalid;
		logic [7:0] aw_a, w_d, rdata;
		logic [1:0] bresp, rresp;
		logic [7:0] rx_data, c2;
		logic [3:0] smb;
		logic       scl_low_timeout_flag, bus_free_high_timeout_flag;
		logic [6:0] a1, a2;
		logic [15:0] slt;
		logic       master_select_bit, tx, acknowledge_control_bit, repeated_start_bit;
		logic       transfer_complete_flag, addressed_as_slave_flag, busy, arbl, srw, iif, rxak;
		logic [2:0] scl_q, sda_q;
		logic       scl_f, sda_f;
		i2cd_ms_t   ms;
		logic [7:0] div;
		logic       scl_lo, sda_lo, act, d_tx, ack_v, ack_w;
		logic       addr_b, first, slv;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [5:0] pre;
		logic [15:0] lo_cnt, hi_cnt;
	} i2cd_st_t;
endpackage

// File: sim/i2cd_peer.sv
/*
 * Behavioural two-wire slave that faces the block on the bench.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
module i2cd_peer (
	// Resolved lines
	input  wire logic       scl,
	input  wire logic       sda,
	// Bench controls
	input  wire logic       stretch,
	input  wire logic [7:0] tx_byte,
	// Pull-downs and captured bytes
	output logic            scl_low,
	output logic            sda_low,
	output logic [7:0]      addr_byte,
	output logic [7:0]      rx_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       rd;
	logic       first;
	logic [7:0] sh;
	// Stretching happens only when the bench commands it.
	assign scl_low = stretch;
	initial sda_low = 1'b0;
	// One frame from START to STOP; a STOP cuts off any byte under way.
	always begin
		@(negedge sda iff scl === 1'b1);
		first = 1'b1;
		fork : frame
			@(posedge sda iff scl === 1'b1);
			forever begin
				if (first || !rd) begin
					for (int i = 0; i < 8; i++) begin
						@(posedge scl);
						sh = {sh[6:0], sda};
					end
					@(negedge scl);
					sda_low = 1'b1;
					@(negedge scl);
					sda_low = 1'b0;
					if (first) begin
						addr_byte = sh;
						rd = sh[0];
					end else begin
						rx_byte = sh;
					end
					first = 1'b0;
				end else begin
					// Data changes only while the clock is low.
					for (int i = 0; i < 8; i++) begin
						sda_low = !tx_byte[7 - i];
						@(negedge scl);
					end
					sda_low = 1'b0;
					@(posedge scl);
					// A NACK ends our sending; the line stays released for the STOP.
					if (sda) wait (1'b0);
					@(negedge scl);
				end
			end
		join_any
		disable frame;
		sda_low = 1'b0;
	end
endmodule

// File: sim/testbench.sv
/*
 * Self-checking bench: AXI4-Lite register tasks and two-wire traffic.
 * Assumes the peer model answers as a slave and lines have pull-ups.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk, aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        scl_out, scl_oen, sda_out, sda_oen, scl_low, sda_low, stretch;
	logic        scl_w, sda_w;
	logic [7:0]  d, tx_byte, addr_byte, rx_byte;
	int          err_count, checks_done;
	logic [7:0]  offs [5] = '{i2cd_pkg::OFF_C2, i2cd_pkg::OFF_SMB, i2cd_pkg::OFF_A2,
	                          i2cd_pkg::OFF_SLTH, i2cd_pkg::OFF_SLTL};
	logic [7:0]  wv [5] = '{8'hc7, 8'hfc, 8'hfe, 8'h12, 8'h34};
	logic [7:0]  ev [5] = '{8'hc7, 8'hf0, 8'hfe, 8'h12, 8'h34};
	// The bus-free flag may rise at any idle moment, so it is masked here.
	logic [7:0]  msk [5] = '{8'hff, 8'hfb, 8'hff, 8'hff, 8'hff};
	// Wired-AND of the open-drain lines with pull-ups.
	assign scl_w = (scl_oen | scl_out) & ~scl_low;
	assign sda_w = (sda_oen | sda_out) & ~sda_low;
	i2cd_top i_i2cd_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oen(scl_oen), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oen(sda_oen));
	i2cd_peer i_i2cd_peer (.scl(scl_w), .sda(sda_w), .stretch(stretch), .tx_byte(tx_byte),
		.scl_low(scl_low), .sda_low(sda_low), .addr_byte(addr_byte), .rx_byte(rx_byte));
	// Free-running 40 MHz clock.
	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;
	// One write; address and data are offered together and released as taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge aclk);
		awaddr  <= 32'(a);
		wdata   <= 32'(v);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	// One read; data and response are taken at the edge that sees rvalid.
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= 32'(a);
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask
	// Byte comparison, counted.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Polls status until the byte-complete flag shows.
	task automatic done();
		do rd(i2cd_pkg::OFF_STAT); while (d[i2cd_pkg::ST_TCF] !== 1'b1);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog sized well above the four bytes and polling of the run.
	initial begin
		repeat (60000) @(posedge aclk);
		err_count++;
		report_and_stop();
	end
	// Test sequence.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, stretch} = 7'h00;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'h1;
		tx_byte = 8'hc3;
		err_count = 0;
		checks_done = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(offs[i]);
			chk(d & msk[i], 8'h00);
			wr(offs[i], wv[i]);
			rd(offs[i]);
			chk(d & msk[i], ev[i]);
			wr(offs[i], 8'h00);
		end
		wr(8'h24, 8'h01);
		chk({6'h0, r}, {6'h0, i2cd_pkg::RESP_SLV});
		rd(8'h24);
		chk({6'h0, r}, {6'h0, i2cd_pkg::RESP_SLV});
		wr(i2cd_pkg::OFF_DATA, 8'h77);
		rd(i2cd_pkg::OFF_DATA);
		chk(d, 8'h00);
		$display("test registers done");
		wr(i2cd_pkg::OFF_CTRL, 8'h30);
		// The address byte is only taken once the start has been sent, two half periods on.
		repeat (3 * i2cd_pkg::HALF_CYC) @(posedge aclk);
		wr(i2cd_pkg::OFF_DATA, 8'ha0);
		done();
		chk(addr_byte, 8'ha0);
		wr(i2cd_pkg::OFF_DATA, 8'h5a);
		rd(i2cd_pkg::OFF_STAT);
		chk({7'h0, d[i2cd_pkg::ST_TCF]}, 8'h00);
		done();
		chk(rx_byte, 8'h5a);
		chk({7'h0, d[i2cd_pkg::ST_RXAK]}, 8'h00);
		rd(i2cd_pkg::OFF_DATA);
		chk(d, 8'h00);
		wr(i2cd_pkg::OFF_CTRL, 8'h10);
		repeat (1000) @(posedge aclk);
		$display("test master transmit done");
		wr(i2cd_pkg::OFF_CTRL, 8'h30);
		repeat (3 * i2cd_pkg::HALF_CYC) @(posedge aclk);
		wr(i2cd_pkg::OFF_DATA, 8'ha1);
		done();
		chk(addr_byte, 8'ha1);
		wr(i2cd_pkg::OFF_CTRL, 8'h28);
		rd(i2cd_pkg::OFF_DATA);
		done();
		wr(i2cd_pkg::OFF_CTRL, 8'h38);
		rd(i2cd_pkg::OFF_DATA);
		chk(d, 8'hc3);
		rd(i2cd_pkg::OFF_STAT);
		chk({7'h0, d[i2cd_pkg::ST_TCF]}, 8'h01);
		wr(i2cd_pkg::OFF_CTRL, 8'h18);
		repeat (1000) @(posedge aclk);
		$display("test master receive done");
		wr(i2cd_pkg::OFF_SMB, 8'h10);
		wr(i2cd_pkg::OFF_SLTL, 8'h20);
		stretch <= 1'b1;
		repeat (100) @(posedge aclk);
		stretch <= 1'b0;
		rd(i2cd_pkg::OFF_SMB);
		chk({7'h0, d[i2cd_pkg::SMB_SCL_LOW_TIMEOUT_FLAG]}, 8'h01);
		rd(i2cd_pkg::OFF_STAT);
		chk({7'h0, d[i2cd_pkg::ST_IIF]}, 8'h01);
		wr(i2cd_pkg::OFF_SMB, 8'h18);
		rd(i2cd_pkg::OFF_SMB);
		chk({7'h0, d[i2cd_pkg::SMB_SCL_LOW_TIMEOUT_FLAG]}, 8'h00);
		wr(i2cd_pkg::OFF_STAT, 8'h02);
		wr(i2cd_pkg::OFF_SLTL, 8'h00);
		stretch <= 1'b1;
		repeat (100) @(posedge aclk);
		stretch <= 1'b0;
		rd(i2cd_pkg::OFF_SMB);
		chk({7'h0, d[i2cd_pkg::SMB_SCL_LOW_TIMEOUT_FLAG]}, 8'h00);
		// Bus-free detection is only meaningful at the divided counter rate.
		wr(i2cd_pkg::OFF_SMB, 8'h00);
		wr(i2cd_pkg::OFF_SLTH, 8'h04);
		stretch <= 1'b1;
		repeat (20) @(posedge aclk);
		rd(i2cd_pkg::OFF_SMB);
		chk({7'h0, d[i2cd_pkg::SMB_BUS_FREE_HIGH_TIMEOUT_FLAG]}, 8'h00);
		stretch <= 1'b0;
		// Threshold is value/512, two ticks of 64 clocks, so four ticks is ample.
		repeat (4 * 64) @(posedge aclk);
		rd(i2cd_pkg::OFF_SMB);
		chk({7'h0, d[i2cd_pkg::SMB_BUS_FREE_HIGH_TIMEOUT_FLAG]}, 8'h01);
		$display("test timeouts done");
		report_and_stop();
	end
endmodule
